/* File: design/system_control.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Lower vector number has higher priority
// - Timer channels 4..0 map to vectors 9..5
// - Lock loss, gated, goes to vector 4
// - Pin interrupt flag, gated, goes to vector 2
// - Software interrupt uses vector 1, unmaskable
// - All reset sources fetch reset vector 0
// - Detector enabled only when monitor enable set
// - Detector off in stop unless stop enable
// - Both enables set: stop3 instead of stop2
// - Power-on holds reset until above threshold
// - Power-on sets power-on and low-voltage status
// - Low-voltage reset only when its enable set
// - Threshold select bit chooses detection level
// - Reset held while supply below threshold
// - Low-voltage status set by either reset
// - Warning sets flag; enabled raises vector 3
// - Clock output off when select is zero
// - Nonzero select drives divided clock, overrides direction
// - Select value sets the division ratio
// - Pin slew and drive apply to clock
// - High byte first, low byte next address
// - Request only when flag and enable set, except software interrupt and reset
module system_control
  import sysctl_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  // AXI4-Lite slave
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Analog comparators and sources
  input  wire logic                    power_on_detect,
  input  wire logic                    below_low_threshold,
  input  wire logic                    below_high_threshold,
  input  wire logic                    warning_detect,
  input  wire logic                    stop_request,
  input  wire reset_src_t              reset_sources,
  input  wire logic                    watchdog_enable,
  input  wire logic                    clock_monitor_enable,
  input  wire logic [NUM_TIMER_CH-1:0] timer_channel_flag,
  input  wire logic [NUM_TIMER_CH-1:0] timer_channel_interrupt_enable,
  input  wire logic                    lock_loss_status,
  input  wire logic                    lock_loss_interrupt_enable,
  input  wire logic                    pin_interrupt_flag,
  input  wire logic                    pin_interrupt_enable,
  input  wire logic                    shared_port_pin_data,
  input  wire logic                    shared_port_pin_dir,
  // To core and system
  output vector_req_t                  vector_req,
  output logic                         system_reset,
  output logic                         detector_enable,
  output logic                         threshold_select,
  output power_mode_t                  power_mode,
  output pin_drive_t                   shared_port_pin
);

  // ====================================================================
  // Control and status state
  logic [31:0] ctrl;
  logic        low_voltage_warning_flag;
  logic [7:0]  reset_source_status;
  logic        por_seen;
  logic        lvr_hold;
  logic        stopped;

  wire supply_monitor_enable      = ctrl[CTRL_MON_EN];
  wire supply_monitor_stop_enable = ctrl[CTRL_MON_STOP_EN];
  wire low_voltage_reset_enable   = ctrl[CTRL_LVR_EN];
  wire warning_interrupt_enable   = ctrl[CTRL_WARN_IE];
  wire [CLKSEL_W-1:0] clock_output_select = ctrl[CTRL_CLKSEL_LSB +: CLKSEL_W];

  // ====================================================================
  // Supply monitor
  // Detection is meaningless while stopped unless the stop enable keeps it on
  assign detector_enable  = supply_monitor_enable &&
                            (!stopped || supply_monitor_stop_enable);
  assign threshold_select = ctrl[CTRL_THR_SEL];
  wire below_selected = threshold_select ? below_high_threshold : below_low_threshold;
  wire lv_trip        = detector_enable && below_selected;
  wire lv_reset_event = lv_trip && low_voltage_reset_enable;

  // Sources gated by their enables; the debugger-forced reset leaves no status
  wire wdog_rst = reset_sources.wdog && watchdog_enable;
  wire clk_rst  = reset_sources.clock_loss && clock_monitor_enable;
  wire other_rst = wdog_rst || clk_rst || reset_sources.pin || reset_sources.bad_opcode ||
                   reset_sources.bad_address || reset_sources.debugger;

  // Power-on hold releases only once the low threshold is exceeded, regardless
  // of the enables, since software has not had a chance to run yet.
  wire por_hold  = power_on_detect || (por_seen && below_low_threshold);
  wire lvr_next  = lv_reset_event || (lvr_hold && below_selected);
  assign system_reset = por_hold || lvr_hold || other_rst;

  wire [7:0] next_status_other = {1'b0, reset_sources.pin, wdog_rst, reset_sources.bad_opcode,
                                  reset_sources.bad_address, clk_rst, 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_seen            <= 1'b1;
      lvr_hold            <= 1'b0;
      reset_source_status <= 8'h82;
    end else if (ce) begin
      por_seen <= por_hold;
      lvr_hold <= lvr_next;
      if (power_on_detect) begin
        reset_source_status <= 8'h82;
      end else if (lv_reset_event && !lvr_hold) begin
        reset_source_status <= {reset_source_status[RS_POR], 7'h02};
      end else if (other_rst && !reset_sources.debugger && !por_hold && !lvr_hold) begin
        reset_source_status <= next_status_other;
      end
    end
  end

  // ====================================================================
  // Stop mode selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stopped    <= 1'b0;
      power_mode <= PWR_RUN;
    end else if (ce) begin
      stopped <= stop_request;
      if (!stop_request) begin
        power_mode <= PWR_RUN;
      end else if (supply_monitor_enable && supply_monitor_stop_enable) begin
        power_mode <= PWR_STOP3;
      end else begin
        power_mode <= PWR_STOP2;
      end
    end
  end

  // ====================================================================
  // Warning flag: set wins over a software acknowledge in the same cycle
  wire warn_set = detector_enable && warning_detect;
  logic warn_ack;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_voltage_warning_flag <= 1'b0;
    end else if (ce) begin
      if (warn_set) begin
        low_voltage_warning_flag <= 1'b1;
      end else if (warn_ack) begin
        low_voltage_warning_flag <= 1'b0;
      end
    end
  end

  // ====================================================================
  // Vector arbitration
  logic [NUM_VEC-1:0] pending;
  always_comb begin
    pending            = '0;
    pending[VEC_RESET] = system_reset;
    pending[VEC_SWI]   = reset_sources.swi;
    pending[VEC_PIN]   = pin_interrupt_flag && pin_interrupt_enable;
    pending[VEC_WARN]  = low_voltage_warning_flag && warning_interrupt_enable;
    pending[VEC_LOCK]  = lock_loss_status && lock_loss_interrupt_enable;
    for (int i = 0; i < NUM_TIMER_CH; i++) begin
      pending[5 + i] = timer_channel_flag[i] && timer_channel_interrupt_enable[i];
    end
  end

  logic [3:0] winner;
  always_comb begin
    winner = '0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        winner = 4'(i);
      end
    end
  end

  // Vector n lives at the top minus two bytes per number; the high byte sits at
  // this address and the low byte one above it.
  wire [15:0] winner_addr = VEC_TOP_ADDR - {11'h000, winner, 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_req <= '0;
    end else if (ce) begin
      vector_req.valid   <= |pending;
      vector_req.number  <= winner;
      vector_req.address <= winner_addr;
    end
  end

  // ====================================================================
  // Clock output on the shared pin
  logic div_clk;
  clock_out_divider u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .select  (clock_output_select),
    .clk_out (div_clk)
  );

  wire clk_out_on = (clock_output_select != '0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_port_pin <= '0;
    end else if (ce) begin
      shared_port_pin.out   <= clk_out_on ? div_clk : shared_port_pin_data;
      shared_port_pin.oe    <= clk_out_on || shared_port_pin_dir;
      shared_port_pin.slew  <= ctrl[CTRL_SLEW];
      shared_port_pin.drive <= ctrl[CTRL_DRIVE];
    end
  end

  // ====================================================================
  // AXI4-Lite slave
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;

  wire        aw_now   = aw_held || (s_axi_awvalid && s_axi_awready);
  wire        w_now    = w_held || (s_axi_wvalid && s_axi_wready);
  wire [7:0]  wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb  = w_held ? w_strb : s_axi_wstrb;
  wire        wr_go    = ce && aw_now && w_now && !s_axi_bvalid;
  wire        wr_ctrl  = wr_go && (wr_addr == REG_CTRL_ADDR);
  wire        wr_known = (wr_addr == REG_CTRL_ADDR) || (wr_addr == REG_STATUS_ADDR) ||
                         (wr_addr == REG_RESET_ADDR) || (wr_addr == REG_VECTOR_ADDR);

  logic [31:0] strb_mask;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      strb_mask[8*b +: 8] = {8{wr_strb[b]}};
    end
  end
  wire [31:0] next_ctrl = (ctrl & ~(strb_mask & CTRL_WRITABLE)) |
                          (wr_data & strb_mask & CTRL_WRITABLE);
  assign warn_ack = wr_ctrl && wr_strb[0] && wr_data[CTRL_WARN_ACK];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      ctrl         <= CTRL_RESET;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready && !wr_go) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl <= next_ctrl;
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      REG_CTRL_ADDR:   rd_mux = ctrl;
      REG_STATUS_ADDR: rd_mux = {29'h0, system_reset, detector_enable, low_voltage_warning_flag};
      REG_RESET_ADDR:  rd_mux = {24'h0, reset_source_status};
      REG_VECTOR_ADDR: rd_mux = {vector_req.valid, 11'h000, vector_req.number,
                                 vector_req.address};
      default:         rd_mux = '0;
    endcase
  end
  wire rd_known = (s_axi_araddr == REG_CTRL_ADDR) || (s_axi_araddr == REG_STATUS_ADDR) ||
                  (s_axi_araddr == REG_RESET_ADDR) || (s_axi_araddr == REG_VECTOR_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: design/sysctl_pkg.sv */
package sysctl_pkg;

  // =====================================================================
  // Register map (byte addresses on AXI4-Lite)
  localparam logic [7:0] REG_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] REG_STATUS_ADDR = 8'h04;
  localparam logic [7:0] REG_RESET_ADDR  = 8'h08;
  localparam logic [7:0] REG_VECTOR_ADDR = 8'h0C;

  // =====================================================================
  // Control register fields
  localparam int CTRL_MON_EN      = 0;
  localparam int CTRL_MON_STOP_EN = 1;
  localparam int CTRL_LVR_EN      = 2;
  localparam int CTRL_THR_SEL     = 3;
  localparam int CTRL_WARN_IE     = 4;
  localparam int CTRL_WARN_ACK    = 5;
  localparam int CTRL_CLKSEL_LSB  = 8;
  localparam int CLKSEL_W         = 3;
  localparam int CTRL_SLEW        = 12;
  localparam int CTRL_DRIVE       = 13;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
  localparam logic [31:0] CTRL_WRITABLE  = 32'h0000_371F;

  // =====================================================================
  // Status register fields
  localparam int STAT_WARN_FLAG   = 0;
  localparam int STAT_DETECT_ON   = 1;
  localparam int STAT_IN_RESET    = 2;

  // Reset-source status bit positions
  localparam int RS_POR  = 7;
  localparam int RS_PIN  = 6;
  localparam int RS_WDOG = 5;
  localparam int RS_OPC  = 4;
  localparam int RS_ADR  = 3;
  localparam int RS_CLK  = 2;
  localparam int RS_LVD  = 1;

  // =====================================================================
  // Vectors
  localparam int NUM_VEC = 10;
  localparam logic [15:0] VEC_TOP_ADDR = 16'hFFFE;
  localparam logic [3:0]  VEC_RESET    = 4'h0;
  localparam logic [3:0]  VEC_SWI      = 4'h1;
  localparam logic [3:0]  VEC_PIN      = 4'h2;
  localparam logic [3:0]  VEC_WARN     = 4'h3;
  localparam logic [3:0]  VEC_LOCK     = 4'h4;
  localparam logic [3:0]  VEC_TIMER0   = 4'h5;
  localparam int NUM_TIMER_CH = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_STOP2,
    PWR_STOP3
  } power_mode_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] number;
    logic [15:0] address;
  } vector_req_t;

  typedef struct packed {
    logic swi;
    logic wdog;
    logic clock_loss;
    logic pin;
    logic bad_opcode;
    logic bad_address;
    logic debugger;
  } reset_src_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic slew;
    logic drive;
  } pin_drive_t;

endpackage

/* File: design/clock_out_divider.sv */
`timescale 1ns/1ps
module clock_out_divider
  import sysctl_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  input  wire logic [CLKSEL_W-1:0] select,
  output logic                     clk_out
);
  // Division by 2*select: a toggle every select bus cycles
  logic [CLKSEL_W-1:0] count;
  wire                 active = (select != '0);
  wire                 wrap   = (count >= select - 3'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count   <= '0;
      clk_out <= 1'b0;
    end else if (ce) begin
      if (!active) begin
        count   <= '0;
        clk_out <= 1'b0;
      end else if (wrap) begin
        count   <= '0;
        clk_out <= ~clk_out;
      end else begin
        count <= count + 3'h1;
      end
    end
  end
endmodule

/* File: tb/vector_fetch_core.sv */
`timescale 1ns/1ps
module vector_fetch_core
  import sysctl_pkg::*;
(
  input  wire vector_req_t vector_req,
  input  wire logic        system_reset,
  output logic [15:0]      fetch_lo
);
  // ==========
  // Vector fetch
  // Low byte sits one above; no fetch in reset
  assign fetch_lo = (vector_req.valid && !system_reset) ? vector_req.address + 16'h0001
                                                        : 16'h0000;
endmodule

/* File: tb/system_control_assertions.sv */
`timescale 1ns/1ps
module system_control_checker
  import sysctl_pkg::*;
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    ce,
  input wire logic                    power_on_detect,
  input wire logic                    below_low_threshold,
  input wire logic                    stop_request,
  input wire reset_src_t              reset_sources,
  input wire logic [NUM_TIMER_CH-1:0] timer_channel_flag,
  input wire logic [NUM_TIMER_CH-1:0] timer_channel_interrupt_enable,
  input wire logic                    lock_loss_status,
  input wire logic                    lock_loss_interrupt_enable,
  input wire logic                    pin_interrupt_flag,
  input wire logic                    pin_interrupt_enable,
  input wire vector_req_t             vector_req,
  input wire logic                    system_reset,
  input wire logic                    detector_enable,
  input wire power_mode_t             power_mode
);
  // ==========
  // Sequences
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_por_hold;
    power_on_detect ##1 (!power_on_detect && below_low_threshold) [*3];
  endsequence
  sequence s_hard_src;
    reset_sources.pin || reset_sources.bad_opcode || reset_sources.bad_address
      || reset_sources.debugger;
  endsequence
  // ==========
  // Properties
  a_vec_addr: assert property (vector_req.valid |->
    vector_req.address == VEC_TOP_ADDR - {11'h000, vector_req.number, 1'b0})
    else $error("bad vector address");
  a_pin_vec: assert property (ce && pin_interrupt_flag && pin_interrupt_enable |=>
    vector_req.valid && vector_req.number <= VEC_PIN) else $error("pin not presented");
  a_swi_vec: assert property (ce && reset_sources.swi |=>
    vector_req.valid && vector_req.number <= VEC_SWI) else $error("swi not presented");
  a_lock_vec: assert property (ce && lock_loss_status &&
    lock_loss_interrupt_enable |=> vector_req.valid && vector_req.number <= VEC_LOCK)
    else $error("lock not presented");
  a_timer_vec: assert property (ce && timer_channel_flag[0] &&
    timer_channel_interrupt_enable[0] |=> vector_req.valid && vector_req.number <= VEC_TIMER0)
    else $error("timer not presented");
  a_pin_gated: assert property (vector_req.number == VEC_PIN &&
    vector_req.valid |-> $past(pin_interrupt_flag) && $past(pin_interrupt_enable))
    else $error("ungated pin vector");
  a_lock_gated: assert property (vector_req.number == VEC_LOCK &&
    vector_req.valid |-> $past(lock_loss_status) && $past(lock_loss_interrupt_enable))
    else $error("ungated lock vector");
  a_por_hold: assert property (s_por_hold |-> system_reset)
    else $error("power-on hold lost");
  a_src_reset: assert property (s_hard_src ##1 s_hard_src |-> system_reset)
    else $error("source did not reset");
  a_stop3_on: assert property (power_mode == PWR_STOP3 |-> detector_enable)
    else $error("detector off in stop3");
  a_stop2_off: assert property (power_mode == PWR_STOP2 && stop_request &&
    $past(stop_request) |-> !detector_enable) else $error("detector on in stop2");
endmodule
bind system_control system_control_checker u_checker (.*);

/* File: tb/test_system_control.sv */
`timescale 1ns/1ps
module test_system_control;
  import sysctl_pkg::*;
  // ==========
  // Signals
  logic        aclk, aresetn, ce;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        power_on_detect, below_low_threshold, below_high_threshold, warning_detect;
  logic        stop_request, watchdog_enable, clock_monitor_enable, lock_loss_status;
  logic        lock_loss_interrupt_enable, pin_interrupt_flag, pin_interrupt_enable;
  logic        shared_port_pin_data, shared_port_pin_dir, system_reset, detector_enable;
  logic        threshold_select;
  logic [4:0]  timer_channel_flag, timer_channel_interrupt_enable;
  reset_src_t  reset_sources;
  vector_req_t vector_req;
  power_mode_t power_mode;
  pin_drive_t  shared_port_pin;
  logic [15:0] fetch_lo;
  int          mismatches, compares, seed, warn_q, t0, t1;

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  system_control u_dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .power_on_detect, .below_low_threshold, .below_high_threshold,
    .warning_detect, .stop_request, .reset_sources, .watchdog_enable, .clock_monitor_enable,
    .timer_channel_flag, .timer_channel_interrupt_enable, .lock_loss_status,
    .lock_loss_interrupt_enable, .pin_interrupt_flag, .pin_interrupt_enable,
    .shared_port_pin_data, .shared_port_pin_dir, .vector_req, .system_reset, .detector_enable,
    .threshold_select, .power_mode, .shared_port_pin
  );
  vector_fetch_core u_core (.vector_req, .system_reset, .fetch_lo);

  // ==========
  // Tasks
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Lowest pending number wins; reset kept out
  function automatic int model_vec();
    if (reset_sources.swi) return 1;
    if (pin_interrupt_flag && pin_interrupt_enable) return 2;
    if (warn_q != 0) return 3;
    if (lock_loss_status && lock_loss_interrupt_enable) return 4;
    for (int i = 0; i < 5; i++) begin
      if (timer_channel_flag[i] && timer_channel_interrupt_enable[i]) return 5 + i;
    end
    return -1;
  endfunction
  task automatic chk_vec(input int v);
    if (v < 0) begin
      chk(32'(vector_req.valid), 32'h0);
    end else begin
      chk({vector_req.valid, 11'h0, vector_req.number, vector_req.address},
          {1'b1, 11'h0, 4'(v), 16'hFFFE - 16'(2 * v)});
      chk(32'(fetch_lo), 32'(16'hFFFF - 16'(2 * v)));
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic pa, pw, done;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    pa = 1'b1;
    pw = wr;
    done = 1'b0;
    n = 0;
    while (!done && n < 50) begin
      @(posedge aclk);
      n++;
      done = wr ? (s_axi_bvalid === 1'b1) : (s_axi_rvalid === 1'b1);
      if (pa && (wr ? s_axi_awready : s_axi_arready) === 1'b1) begin
        pa = 1'b0;
        if (wr) s_axi_awvalid <= 1'b0;
        else s_axi_arvalid <= 1'b0;
      end
      if (pw && s_axi_wready === 1'b1) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    rd = s_axi_rdata;
    rr = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!done) begin
      mismatches++;
      test_done();
    end
  endtask

  // ==========
  // Scenarios
  initial begin
    seed = 32'hc619f22e;
    {mismatches, compares, warn_q} = '0;
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, power_on_detect, warning_detect} = '0;
    {stop_request, watchdog_enable, clock_monitor_enable, lock_loss_status} = '0;
    {lock_loss_interrupt_enable, pin_interrupt_flag, pin_interrupt_enable} = '0;
    {shared_port_pin_data, shared_port_pin_dir, timer_channel_flag} = '0;
    {timer_channel_interrupt_enable, reset_sources} = '0;
    {ce, below_low_threshold, below_high_threshold, s_axi_wstrb} = 7'h7F;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi(0, REG_CTRL_ADDR, 0);
    chk(rd, CTRL_RESET);
    axi(0, REG_RESET_ADDR, 0);
    chk(rd, 32'h0000_0082);
    axi(0, 8'h10, 0);
    chk({rd[29:0], rr}, {30'h0, RESP_SLVERR});
    power_on_detect <= 1'b1;
    @(posedge aclk);
    power_on_detect <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    chk(32'(system_reset), 32'h1);
    {below_low_threshold, below_high_threshold} <= 2'b00;
    settle();
    chk(32'(system_reset), 32'h0);
    @(posedge aclk);
    warning_detect <= 1'b1;
    @(posedge aclk);
    warning_detect <= 1'b0;
    settle();
    chk_vec(-1);
    axi(0, REG_STATUS_ADDR, 0);
    chk(32'(rd[STAT_WARN_FLAG]), 32'h1);
    axi(1, REG_CTRL_ADDR, 32'h0000_0011);
    warn_q = 1;
    settle();
    chk_vec(3);
    axi(1, REG_CTRL_ADDR, 32'h0000_0021);
    warn_q = 0;
    settle();
    chk_vec(-1);
    for (int v = 5; v < 10; v++) begin
      @(posedge aclk);
      timer_channel_flag <= 5'(1 << (v - 5));
      timer_channel_interrupt_enable <= 5'(1 << (v - 5));
      settle();
      chk_vec(v);
      timer_channel_interrupt_enable <= 5'h00;
      settle();
      chk_vec(-1);
    end
    for (int k = 0; k < 60; k++) begin
      @(posedge aclk);
      {timer_channel_flag, timer_channel_interrupt_enable} <= 10'($random(seed));
      {lock_loss_status, lock_loss_interrupt_enable} <= 2'($random(seed));
      {pin_interrupt_flag, pin_interrupt_enable} <= 2'($random(seed));
      reset_sources.swi <= ($random(seed) % 4) == 0;
      settle();
      chk_vec(model_vec());
    end
    @(posedge aclk);
    reset_sources <= '0;
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      reset_sources <= 7'(1 << i);
      settle();
      chk(32'(system_reset), (i < 4) ? 32'h1 : 32'h0);
      {watchdog_enable, clock_monitor_enable} <= 2'b11;
      settle();
      chk(32'(system_reset), 32'h1);
      {watchdog_enable, clock_monitor_enable, reset_sources} <= '0;
      settle();
    end
    @(posedge aclk);
    {below_low_threshold, below_high_threshold} <= 2'b11;
    settle();
    chk(32'(system_reset), 32'h0);
    axi(1, REG_CTRL_ADDR, 32'h0000_0005);
    settle();
    chk(32'(system_reset), 32'h1);
    {below_low_threshold, below_high_threshold} <= 2'b00;
    settle();
    chk(32'(system_reset), 32'h0);
    axi(1, REG_CTRL_ADDR, 32'h0000_0008);
    settle();
    chk({30'h0, threshold_select, detector_enable}, 32'h2);
    for (int m = 1; m < 4; m += 2) begin
      axi(1, REG_CTRL_ADDR, 32'(m));
      stop_request <= 1'b1;
      settle();
      chk({power_mode, detector_enable},
          (m == 3) ? {PWR_STOP3, 1'b1} : {PWR_STOP2, 1'b0});
      stop_request <= 1'b0;
      settle();
      chk(32'(detector_enable), 32'h1);
    end
    {shared_port_pin_data, shared_port_pin_dir} <= 2'b11;
    axi(1, REG_CTRL_ADDR, 32'h0000_0001);
    settle();
    chk({shared_port_pin.out, shared_port_pin.oe}, 2'b11);
    for (int s = 1; s < 8; s++) begin
      {shared_port_pin_data, shared_port_pin_dir} <= 2'b00;
      axi(1, REG_CTRL_ADDR, 32'h0000_3001 | 32'(s << CTRL_CLKSEL_LSB));
      t0 = -2;
      t1 = -1;
      // Low first: a select change can leave a partial high phase
      for (int n = 0; n < 60 && t1 < 0; n++) begin
        @(posedge aclk);
        #1;
        if (!shared_port_pin.out && t0 == -2) t0 = -1;
        if (shared_port_pin.out && t0 == -1) t0 = n;
        if (!shared_port_pin.out && t0 >= 0) t1 = n;
      end
      chk(32'(t1 - t0), 32'(s));
      chk({shared_port_pin.oe, shared_port_pin.slew,
           shared_port_pin.drive}, 3'b111);
    end
    axi(1, REG_CTRL_ADDR, 32'h0000_0001);
    settle();
    chk({shared_port_pin.out, shared_port_pin.oe}, 2'b00);
    test_done();
  end
endmodule
